// file: src/scmc_defs.svh
// What this block does
// - The system clock comes from the fast clock or the sub clock as the 3-bit select field chooses.
// - The fast clock comes from the fast RC oscillator and the sub clock from the slow RC oscillator.
// - In NORMAL mode, codes 000 to 110 run the CPU from the fast clock divided by 1 up to 64, all clocks on.
// - In SLOW mode, code 111 runs the CPU from the sub clock off the slow RC oscillator.
// - On a move to the sub clock the fast oscillator keeps running or stops as its enable bit says.
// - There are six modes: NORMAL and SLOW with the CPU on, SLEEP and three IDLE modes with it off.
// - A stop with both idle-keep bits low enters SLEEP, stopping CPU, system, fast and sub clocks.
// - In SLEEP the slow RC clock runs only while the watchdog is enabled.
// - A stop with fast keep 0 and slow keep 1 enters the sub-only idle; system clock on only for code 111.
// - A stop with both keep bits 1 enters the both-oscillator idle with fast, sub, slow and system clocks on.
// - A stop with fast keep 1 and slow keep 0 enters the fast-only idle; system clock on only for 000 to 110.
// - In NORMAL, SLOW and all idle modes the slow RC clock keeps running.
// - Codes 000 to 110 select fast clock divided by 1, 2, 4, 8, 16, 32, 64; code 111 selects the sub clock.
// - Stopping the fast oscillator clears its stable flag, which sets again once the re-enabled oscillator has settled.
`ifndef SCMC_DEFS_SVH
`define SCMC_DEFS_SVH
`define SCMC_SEL_SUB 3'h7
`define SCMC_SEL_RESET 3'h0
`define SCMC_OSC_RUN_RESET 1'b1
`define SCMC_DIV_W 6
`define SCMC_FAST_SETTLE_NS 16
`define SCMC_CLK_PERIOD_NS 4
`endif

// file: src/scmc_pkg.sv
`default_nettype none
package scmc_pkg;
    // Operating modes, one-hot.
    typedef enum logic [5:0] {
        SCMC_NORMAL = 6'h01,
        SCMC_SLOW = 6'h02,
        SCMC_SLEEP = 6'h04,
        SCMC_IDLE_SUB = 6'h08,
        SCMC_IDLE_BOTH = 6'h10,
        SCMC_IDLE_FAST = 6'h20
    } scmc_mode_t;

    // Clock gates handed to the consumers.
    typedef struct packed {
        logic cpu_clk;
        logic system_clk_out;
        logic fast_clk;
        logic sub_clk;
        logic slow_rc_clk;
    } scmc_gates_t;
endpackage
`default_nettype wire

// file: src/scmc_top.sv
`include "scmc_defs.svh"
`default_nettype none
module scmc_top
    import scmc_pkg::*;
#(
    parameter int SETTLE_CYC = (`SCMC_FAST_SETTLE_NS
        + `SCMC_CLK_PERIOD_NS - 1) / `SCMC_CLK_PERIOD_NS
)
(
    input wire logic clk_sys,
    input wire logic reset,
    // Oscillator pins, asynchronous to clk_sys.
    input wire logic fast_rc_osc,
    input wire logic slow_rc_osc,
    // Control levels, all on clk_sys.
    input wire logic [2:0] sys_clk_select,
    input wire logic fast_osc_idle_keep,
    input wire logic slow_osc_idle_keep,
    input wire logic fast_osc_on,
    input wire logic watchdog_timer,
    // Stop and wake strobes from the CPU core.
    input wire logic halt_req,
    input wire logic wake_req,
    // Clock waveforms sampled on clk_sys and the CPU clock enable, each gated per mode.
    output logic system_clk_out,
    output logic cpu_clk_en,
    output logic fast_clk,
    output logic sub_clk,
    output logic slow_rc_clk,
    // Oscillator enable and its stable flag.
    output logic fast_osc_run,
    output logic fast_osc_stable,
    // Current operating mode, one-hot.
    output scmc_mode_t mode
);
    // Pin synchronisers: first stage feeds only the second.
    // Each oscillator passes four flops before the edge detector, which
    // buys settling time for metastability at the cost of four cycles of
    // lag on every derived clock.
    // The oscillators must stay well below a quarter of clk_sys, since a
    // phase that is sampled only once can be lost entirely.
    logic [1:0] fast_s1, fast_s2, slow_s1, slow_s2;
    logic fast_q, slow_q;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            fast_s1 <= 2'h0;
            slow_s1 <= 2'h0;
            fast_s2 <= 2'h0;
            slow_s2 <= 2'h0;
            fast_q <= 1'b0;
            slow_q <= 1'b0;
        end
        else
        begin
            fast_s1 <= {fast_s1[0], fast_rc_osc};
            fast_s2 <= {fast_s2[0], fast_s1[1]};
            slow_s1 <= {slow_s1[0], slow_rc_osc};
            slow_s2 <= {slow_s2[0], slow_s1[1]};
            fast_q <= fast_s2[1];
            slow_q <= slow_s2[1];
        end
    end
    // Rising edges of the two synchronised oscillators.
    // The previous sample sits one flop behind the synchroniser, so each
    // edge is a single-cycle pulse on clk_sys.
    logic fast_rise, slow_rise;
    assign fast_rise = fast_s2[1] & ~fast_q;
    assign slow_rise = slow_s2[1] & ~slow_q;

    // Mode machine and oscillator enable.
    // A stop request is honoured only in a run mode; in a stop mode it is
    // ignored, so a held request cannot hop from one idle mode to another.
    // Select changes in a run mode move between NORMAL and SLOW at once;
    // the live clock follows later through the ratio switch.
    scmc_mode_t next_mode;
    logic next_osc_run;
    logic [2:0] live_sel, next_live_sel;
    always_comb
    begin
        next_mode = mode;
        case (mode)
            SCMC_NORMAL, SCMC_SLOW:
            begin
                if (halt_req)
                begin
                    // The keep bits count only at the stop edge.
                    case ({fast_osc_idle_keep, slow_osc_idle_keep})
                        2'h0: next_mode = SCMC_SLEEP;
                        2'h1: next_mode = SCMC_IDLE_SUB;
                        2'h2: next_mode = SCMC_IDLE_FAST;
                        default: next_mode = SCMC_IDLE_BOTH;
                    endcase
                end
                else if (sys_clk_select == `SCMC_SEL_SUB)
                    next_mode = SCMC_SLOW;
                else
                    next_mode = SCMC_NORMAL;
            end
            SCMC_SLEEP, SCMC_IDLE_SUB, SCMC_IDLE_BOTH, SCMC_IDLE_FAST:
            begin
                // Wake returns to the run mode the select field names.
                // Wake does not wait for the fast oscillator: the settle counter holds
                // back the divided taps, but code 000 passes the restarting oscillator.
                if (wake_req)
                    next_mode = (sys_clk_select == `SCMC_SEL_SUB) ?
                        SCMC_SLOW : SCMC_NORMAL;
            end
            default: next_mode = SCMC_NORMAL;
        endcase
        next_osc_run = fast_osc_on;
        if (mode == SCMC_SLEEP || mode == SCMC_IDLE_SUB)
            next_osc_run = 1'b0;
        else if (mode == SCMC_IDLE_BOTH || mode == SCMC_IDLE_FAST)
            next_osc_run = 1'b1;
        else if (mode == SCMC_NORMAL)
            next_osc_run = 1'b1;
        // hold until switched
        // In SLOW the oscillator may stop only once the live code is on
        // the sub clock; a fast tap frozen high would stall the switch.
        else if (live_sel != `SCMC_SEL_SUB)
            next_osc_run = 1'b1;
    end
    // Mode and enable registers; the enable starts on, as after power-up.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            mode <= SCMC_NORMAL;
            fast_osc_run <= `SCMC_OSC_RUN_RESET;
        end
        else
        begin
            mode <= next_mode;
            fast_osc_run <= next_osc_run;
        end
    end

    // Settle counter: flag drops while the enable is off and rises after settling.
    // The count restarts whenever the oscillator stops, so even a short
    // off period costs a full settle time; wake latency buys safety.
    // One spare bit keeps the compare clear of wrap-around.
    localparam int CW = $clog2(SETTLE_CYC + 1) + 1;
    logic [CW-1:0] settle, next_settle;
    logic next_stable;
    always_comb
    begin
        next_settle = settle;
        next_stable = fast_osc_stable;
        if (!fast_osc_run)
        begin
            next_settle = '0;
            next_stable = 1'b0;
        end
        else if (settle < CW'(SETTLE_CYC))
            next_settle = settle + CW'(1);
        else
            next_stable = 1'b1;
    end
    // Settle count and flag registers.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            settle <= '0;
            fast_osc_stable <= 1'b0;
        end
        else
        begin
            settle <= next_settle;
            fast_osc_stable <= next_stable;
        end
    end

    // Divider chain on fast edges; bit k toggles at fast/2^(k+1).
    // It advances only on settled edges, since an oscillator that is
    // still starting could leave runt periods on the divided taps.
    logic [`SCMC_DIV_W-1:0] div, next_div;
    logic [`SCMC_DIV_W:0] taps;
    always_comb
    begin
        next_div = div;
        if (fast_rise && fast_osc_stable)
            next_div = div + `SCMC_DIV_W'(1);
    end
    // Divider register.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            div <= '0;
        else
            div <= next_div;
    end
    // Tap 0 is the undivided waveform, tap k the fast clock over 2^k.
    assign taps = {div, fast_s2[1]};

    // Ratio switch: the live code changes only on a low phase of both
    // the old and new taps, so no pulse is ever shortened.
    // Fast codes also wait for the stable flag, so the system clock never
    // moves onto an oscillator that is still starting.
    // Limitation: a change can wait up to one period of the slower tap.
    logic cur_tap, new_tap, fast_ok;
    always_comb
    begin
        cur_tap = (live_sel == `SCMC_SEL_SUB) ? slow_s2[1] : taps[live_sel];
        new_tap = (sys_clk_select == `SCMC_SEL_SUB) ?
            slow_s2[1] : taps[sys_clk_select];
        fast_ok = fast_osc_stable ||
            (sys_clk_select == `SCMC_SEL_SUB);
        next_live_sel = live_sel;
        if (sys_clk_select != live_sel && fast_ok && !cur_tap && !new_tap)
            next_live_sel = sys_clk_select;
    end
    // Live select register.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            live_sel <= `SCMC_SEL_RESET;
        else
            live_sel <= next_live_sel;
    end

    // Clock gating per mode.
    // Every gate is registered so each output comes from a flop; the cost
    // is one more cycle of lag against the mode.
    scmc_gates_t g, next_g;
    logic on_sub;
    always_comb
    begin
        // The live code, not the request, decides which source runs.
        on_sub = (live_sel == `SCMC_SEL_SUB);
        // Defaults run every clock but the CPU's; run modes turn the CPU on, SLEEP and the sub-only and fast-only idles switch some off.
        // system from chosen source
        next_g.system_clk_out = cur_tap;
        next_g.cpu_clk = 1'b0;
        next_g.fast_clk = fast_s2[1] & fast_osc_stable;
        next_g.sub_clk = slow_s2[1];
        next_g.slow_rc_clk = slow_s2[1];
        case (mode)
            SCMC_NORMAL: next_g.cpu_clk = 1'b1;
            SCMC_SLOW: next_g.cpu_clk = 1'b1;
            SCMC_SLEEP:
            begin
                // The watchdog may keep the slow clock; all else stops.
                next_g.system_clk_out = 1'b0;
                next_g.fast_clk = 1'b0;
                next_g.sub_clk = 1'b0;
                next_g.slow_rc_clk = slow_s2[1] & watchdog_timer;
            end
            SCMC_IDLE_SUB:
            begin
                // The sub-only idle stops the fast clock to consumers.
                next_g.fast_clk = 1'b0;
                if (!on_sub)
                    next_g.system_clk_out = 1'b0;
            end
            SCMC_IDLE_FAST:
            begin
                // The fast-only idle stops the sub clock to consumers.
                next_g.sub_clk = 1'b0;
                if (on_sub)
                    next_g.system_clk_out = 1'b0;
            end
            SCMC_IDLE_BOTH: next_g.cpu_clk = 1'b0;
            default: next_g.cpu_clk = 1'b0;
        endcase
    end
    // Gate register.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            g <= '0;
        else
            g <= next_g;
    end
    // Outputs are the gate register's fields, with no logic between.
    assign system_clk_out = g.system_clk_out;
    assign cpu_clk_en = g.cpu_clk;
    assign fast_clk = g.fast_clk;
    assign sub_clk = g.sub_clk;
    assign slow_rc_clk = g.slow_rc_clk;
endmodule
`default_nettype wire

// file: test/scmc_assertions.sv
`default_nettype none
module scmc_checker
    import scmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic fast_osc_idle_keep,
    input wire logic slow_osc_idle_keep,
    input wire logic watchdog_timer,
    input wire logic halt_req,
    input wire logic cpu_clk_en,
    input wire logic fast_clk,
    input wire logic sub_clk,
    input wire logic slow_rc_clk,
    input wire logic fast_osc_run,
    input wire logic fast_osc_stable,
    input wire scmc_mode_t mode
);
    // One clock domain, so clocking and reset are given once.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // A stop only counts while the CPU runs.
    sequence s_halt;
        halt_req && (mode == SCMC_NORMAL || mode == SCMC_SLOW);
    endsequence
    // Gated outputs lag the mode, so SLEEP must have settled.
    sequence s_asleep;
        (mode == SCMC_SLEEP) [*4];
    endsequence
    chk_enter_sleep: assert property (
        s_halt ##0 (!fast_osc_idle_keep && !slow_osc_idle_keep)
        |=> mode == SCMC_SLEEP) else $error("no sleep entry");
    chk_enter_sub: assert property (
        s_halt ##0 (!fast_osc_idle_keep && slow_osc_idle_keep)
        |=> mode == SCMC_IDLE_SUB) else $error("no sub idle entry");
    chk_enter_both: assert property (
        s_halt ##0 (fast_osc_idle_keep && slow_osc_idle_keep)
        |=> mode == SCMC_IDLE_BOTH) else $error("no both idle entry");
    chk_enter_fast: assert property (
        s_halt ##0 (fast_osc_idle_keep && !slow_osc_idle_keep)
        |=> mode == SCMC_IDLE_FAST) else $error("no fast idle entry");
    chk_cpu_stopped: assert property (
        !(mode inside {SCMC_NORMAL, SCMC_SLOW}) [*2] |-> !cpu_clk_en)
        else $error("cpu clock on while stopped");
    chk_sleep_gates: assert property (
        s_asleep |-> !fast_clk && !sub_clk)
        else $error("clock runs in sleep");
    chk_sleep_slow: assert property (
        (mode == SCMC_SLEEP && !watchdog_timer) [*4] |-> !slow_rc_clk)
        else $error("slow clock runs without watchdog");
    chk_osc_off: assert property (
        (mode == SCMC_SLEEP || mode == SCMC_IDLE_SUB) [*2]
        |-> !fast_osc_run) else $error("fast oscillator left on");
    chk_flag_clear: assert property (
        !fast_osc_run |=> !fast_osc_stable)
        else $error("stable flag kept while off");
endmodule
bind scmc_top scmc_checker i_scmc_checker (.clk_sys, .reset,
    .fast_osc_idle_keep, .slow_osc_idle_keep, .watchdog_timer,
    .halt_req, .cpu_clk_en, .fast_clk, .sub_clk, .slow_rc_clk,
    .fast_osc_run, .fast_osc_stable, .mode);
`default_nettype wire

// file: test/scmc_osc_model.sv
`default_nettype none
module scmc_osc_model (
    input wire logic fast_osc_run,
    output logic fast_rc_osc,
    output logic slow_rc_osc
);
    timeunit 1ns;
    timeprecision 1ps;
    // Fast source enable
    // A disabled cell stops low, so a restart really needs settling.
    initial fast_rc_osc = 1'b0;
    always #14 fast_rc_osc = fast_osc_run ? ~fast_rc_osc : 1'b0;
    initial slow_rc_osc = 1'b0;
    always #150 slow_rc_osc = ~slow_rc_osc;
endmodule
`default_nettype wire

// file: test/tb_scmc_top.sv
`default_nettype none
module tb_scmc_top;
    import scmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic fast_rc_osc, slow_rc_osc, halt_req = 1'b0, wake_req = 1'b0;
    logic [2:0] sys_clk_select = 3'h0;
    logic fast_osc_idle_keep = 1'b0, slow_osc_idle_keep = 1'b0;
    logic fast_osc_on = 1'b1, watchdog_timer = 1'b0;
    logic system_clk_out, cpu_clk_en, fast_clk, sub_clk, slow_rc_clk;
    logic fast_osc_run, fast_osc_stable;
    scmc_mode_t mode;
    int failures = 0;
    int num_checks = 0;
    logic [31:0] rng = 32'h3B09;
    // Stop modes indexed by the two keep bits, fast keep high.
    int stop_tab[4] = '{4, 8, 32, 16};
    scmc_top i_scmc_top (.clk_sys, .reset, .fast_rc_osc, .slow_rc_osc,
        .sys_clk_select, .fast_osc_idle_keep, .slow_osc_idle_keep,
        .fast_osc_on, .watchdog_timer, .halt_req, .wake_req,
        .system_clk_out, .cpu_clk_en, .fast_clk, .sub_clk, .slow_rc_clk,
        .fast_osc_run, .fast_osc_stable, .mode);
    scmc_osc_model i_scmc_osc_model (.fast_osc_run, .fast_rc_osc,
        .slow_rc_osc);
    // Free running system clock.
    always #2 clk_sys = ~clk_sys;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Xorshift source for the random control levels.
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Edges are counted once per system cycle after a settling wait, so
    // no output race hides one and the deferred ratio change has landed.
    task automatic ratio(input int code);
        int nf;
        int ns;
        int nb;
        int nl;
        int d;
        logic [3:0] prev;
        nf = 0;
        ns = 0;
        nb = 0;
        nl = 0;
        tick(600);
        prev = {fast_clk, system_clk_out, sub_clk, slow_rc_clk};
        repeat (1792)
        begin
            tick(1);
            nf += int'(fast_clk & ~prev[3]);
            ns += int'(system_clk_out & ~prev[2]);
            nb += int'(sub_clk & ~prev[1]);
            nl += int'(slow_rc_clk & ~prev[0]);
            prev = {fast_clk, system_clk_out, sub_clk, slow_rc_clk};
        end
        d = (code < 7) ? ns - (nf >> code) : ns - nb;
        check("sub runs", nb inside {[22:26]}, 1);
        check("slow runs", nl inside {[22:26]}, 1);
        check("divide", d inside {[-2:2]}, 1);
        if (code < 7)
            check("fast runs", nf inside {[254:258]}, 1);
    endtask
    // Main sequence: one pass per select code, then stop and wake.
    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1 reset = 1'b0;
        for (int c = 0; c < 8; c++)
        begin
            rng = xorshift(rng);
            watchdog_timer = rng[0];
            fast_osc_on = rng[1];
            sys_clk_select = c[2:0];
            fast_osc_idle_keep = c[1];
            slow_osc_idle_keep = c[0];
            for (int k = 0; k < 3000 && mode != (c == 7 ? 2 : 1); k++)
                tick(1);
            check("run mode", mode, c == 7 ? 2 : 1);
            for (int k = 0; k < 200 && fast_osc_stable !== 1'b1; k++)
                tick(1);
            if (c < 7)
                check("stable", fast_osc_stable, 1);
            ratio(c);
            if (c == 7)
                check("osc enable", fast_osc_run, fast_osc_on);
            halt_req = 1'b1;
            tick(1);
            halt_req = 1'b0;
            check("stop mode", mode, stop_tab[c[1:0]]);
            tick(1);
            check("cpu stopped", cpu_clk_en, 0);
            tick(20);
            wake_req = 1'b1;
            tick(1);
            wake_req = 1'b0;
            check("wake mode", mode, c == 7 ? 2 : 1);
            tick(1);
            check("cpu back", cpu_clk_en, 1);
            $display("test %0d done", c);
        end
        conclude();
    end
    // Watchdog at about twice the expected run length.
    initial
    begin
        #160000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
